// [core/ppd_core.sv]
/*
 * Feedback divider, phase comparator and configuration registers of the
 * pixel clock generator. REF_CLK stands for the pixel clock.
 * Assumes HSYNC, HOLD and the register port are synchronous to REF_CLK
 * and that the serial control port lies outside this module.
 */
`timescale 1ns/1ps
module ppd_core (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire ppd_pkg::ppd_reg_req_s REG_REQ,
   input wire logic HSYNC,
   input wire logic HOLD,
   output logic [7:0] REG_RDATA,
   output logic FB_PULSE,
   output logic PUMP_UP,
   output logic PUMP_DOWN,
   output logic [1:0] VCO_RANGE,
   output logic [2:0] PUMP_CODE,
   output logic [23:0] GAIN_RGB,
   output logic [20:0] OFFSET_RGB,
   output logic [4:0] SOG_THRESHOLD,
   output logic SOG_NEGATIVE
);
   import ppd_pkg::*;

   ppd_state_s s_q, s_d;

   function automatic ppd_div_t div_of(input logic [7:0] hi, input logic [7:0] lo);
      div_of = {hi, lo[`PPD_DIV_LO_MSB:`PPD_DIV_LO_LSB]};
   endfunction : div_of

   function automatic logic [7:0] read_reg(input ppd_state_s st, input logic [7:0] a);
      case (a)
         `PPD_ADDR_DIV_HI: read_reg = st.div_hi;
         `PPD_ADDR_DIV_LO: read_reg = st.div_lo;
         `PPD_ADDR_PLL_CTL: read_reg = st.pll_ctl;
         `PPD_ADDR_RED_GAIN: read_reg = st.gain[0];
         `PPD_ADDR_GRN_GAIN: read_reg = st.gain[1];
         `PPD_ADDR_BLU_GAIN: read_reg = st.gain[2];
         `PPD_ADDR_RED_OFS: read_reg = {st.ofs[0], 1'b0};
         `PPD_ADDR_GRN_OFS: read_reg = {st.ofs[1], 1'b0};
         `PPD_ADDR_BLU_OFS: read_reg = {st.ofs[2], 1'b0};
         `PPD_ADDR_SYNC_CTL: read_reg = st.sync_ctl;
         default: read_reg = `PPD_ZERO8;
      endcase
   endfunction : read_reg

   logic sync_edge;

   always_comb begin
      s_d = s_q;
      // Hold masks the reference so coasting lines cannot pull the loop
      sync_edge = HSYNC && !s_q.sync_prev && !HOLD;
      s_d.sync_prev = HSYNC;

      if (REG_REQ.we) begin
         case (REG_REQ.addr)
            `PPD_ADDR_DIV_HI: s_d.div_hi = REG_REQ.wdata;
            `PPD_ADDR_DIV_LO: s_d.div_lo = REG_REQ.wdata;
            `PPD_ADDR_PLL_CTL: s_d.pll_ctl = REG_REQ.wdata;
            `PPD_ADDR_RED_GAIN: s_d.gain[0] = REG_REQ.wdata;
            `PPD_ADDR_GRN_GAIN: s_d.gain[1] = REG_REQ.wdata;
            `PPD_ADDR_BLU_GAIN: s_d.gain[2] = REG_REQ.wdata;
            `PPD_ADDR_RED_OFS: s_d.ofs[0] = REG_REQ.wdata[7:1];
            `PPD_ADDR_GRN_OFS: s_d.ofs[1] = REG_REQ.wdata[7:1];
            `PPD_ADDR_BLU_OFS: s_d.ofs[2] = REG_REQ.wdata[7:1];
            `PPD_ADDR_SYNC_CTL: s_d.sync_ctl = REG_REQ.wdata;
            default: ;
         endcase
      end
      s_d.rdata = read_reg(s_q, REG_REQ.addr);

      // Divisor is sampled only at reload; a reload between the two writes loads a half-written pair
      s_d.fb = 1'b0;
      if (s_q.cnt == '0) begin
         s_d.cnt = div_of(s_q.div_hi, s_q.div_lo);
         s_d.fb = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt - 1'b1;
      end

      // Three-state phase detector; feedback leading means the oscillator runs fast
      case (s_q.pd)
         PPD_PD_IDLE: begin
            if (sync_edge && !s_d.fb) s_d.pd = PPD_PD_UP;
            else if (s_d.fb && !sync_edge) s_d.pd = PPD_PD_DOWN;
         end
         PPD_PD_UP: begin
            if (s_d.fb) s_d.pd = PPD_PD_IDLE;
         end
         PPD_PD_DOWN: begin
            if (sync_edge) s_d.pd = PPD_PD_IDLE;
         end
         default: s_d.pd = PPD_PD_IDLE;
      endcase
      if (HOLD) s_d.pd = PPD_PD_IDLE;
      s_d.up = (s_d.pd == PPD_PD_UP);
      s_d.down = (s_d.pd == PPD_PD_DOWN);
   end

   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         s_q <= '0;
         s_q.div_hi <= `PPD_RST_DIV_HI;
         s_q.div_lo <= `PPD_RST_DIV_LO;
         s_q.pll_ctl <= `PPD_RST_PLL_CTL;
         s_q.gain <= {3{`PPD_RST_GAIN}};
         s_q.ofs <= {3{`PPD_RST_OFS}};
         s_q.sync_ctl <= `PPD_RST_SYNC_CTL;
         s_q.pd <= PPD_PD_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // 12-bit counter divides by 1 to 4096, short of the 170 MHz / 15 kHz ratio of about 11333
   assign FB_PULSE = s_q.fb;
   assign PUMP_UP = s_q.up;
   assign PUMP_DOWN = s_q.down;
   assign REG_RDATA = s_q.rdata;
   assign VCO_RANGE = s_q.pll_ctl[`PPD_RANGE_MSB:`PPD_RANGE_LSB];
   assign PUMP_CODE = s_q.pll_ctl[`PPD_PUMP_MSB:`PPD_PUMP_LSB];
   assign GAIN_RGB = {s_q.gain[2], s_q.gain[1], s_q.gain[0]};
   assign OFFSET_RGB = {s_q.ofs[2], s_q.ofs[1], s_q.ofs[0]};
   assign SOG_THRESHOLD = s_q.sync_ctl[`PPD_SOG_MSB:`PPD_SOG_LSB];
   assign SOG_NEGATIVE = 1'b1;

endmodule : ppd_core

// [core/ppd_defines.svh]
/*
 * Register offsets, field positions, reset values and widths of the
 * pixel clock divider and analog configuration block.
 * Assumes inclusion by bare name from the package and the core module.
 */
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH

`define PPD_AW 8
`define PPD_DW 8
`define PPD_DIV_W 12

`define PPD_ADDR_DIV_HI 8'h01
`define PPD_ADDR_DIV_LO 8'h02
`define PPD_ADDR_PLL_CTL 8'h03
`define PPD_ADDR_RED_GAIN 8'h08
`define PPD_ADDR_GRN_GAIN 8'h09
`define PPD_ADDR_BLU_GAIN 8'h0A
`define PPD_ADDR_RED_OFS 8'h0B
`define PPD_ADDR_GRN_OFS 8'h0C
`define PPD_ADDR_BLU_OFS 8'h0D
`define PPD_ADDR_SYNC_CTL 8'h10

// Low divisor register keeps divisor bits 3:0 in its upper nibble
`define PPD_DIV_LO_MSB 7
`define PPD_DIV_LO_LSB 4
// Control register at 0x03: range in 7:6, pump code in 5:3
`define PPD_RANGE_MSB 7
`define PPD_RANGE_LSB 6
`define PPD_PUMP_MSB 5
`define PPD_PUMP_LSB 3
// Slicer threshold field in 7:3 of 0x10
`define PPD_SOG_MSB 7
`define PPD_SOG_LSB 3

`define PPD_RST_DIV_HI 8'h69
`define PPD_RST_DIV_LO 8'hD0
`define PPD_RST_PLL_CTL 8'h48
`define PPD_RST_GAIN 8'h80
`define PPD_RST_OFS 7'h40
`define PPD_RST_SYNC_CTL 8'h78
`define PPD_ZERO8 8'h00

`endif

// [core/ppd_pkg.sv]
/*
 * Types shared by the pixel clock divider and configuration block.
 * Assumes ppd_defines.svh is on the include path.
 */
package ppd_pkg;
`include "ppd_defines.svh"

   typedef logic [`PPD_DIV_W-1:0] ppd_div_t;

   // Register write/read port behind the serial control port
   typedef struct packed {
      logic we;
      logic [`PPD_AW-1:0] addr;
      logic [`PPD_DW-1:0] wdata;
   } ppd_reg_req_s;

   typedef enum logic [1:0] {
      PPD_PD_IDLE,
      PPD_PD_UP,
      PPD_PD_DOWN
   } ppd_pd_e;

   typedef struct packed {
      logic [7:0] div_hi;
      logic [7:0] div_lo;
      logic [7:0] pll_ctl;
      logic [2:0][7:0] gain;
      logic [2:0][6:0] ofs;
      logic [7:0] sync_ctl;
      ppd_div_t cnt;
      logic fb;
      logic sync_prev;
      ppd_pd_e pd;
      logic up;
      logic down;
      logic [7:0] rdata;
   } ppd_state_s;

endpackage : ppd_pkg

// [verification/ppd_checker.sv]
/* Port checker for ppd_core.
   Assumes bind to every ppd_core. */
`timescale 1ns/1ps
module ppd_checker (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire ppd_pkg::ppd_reg_req_s REG_REQ,
   input wire logic HSYNC,
   input wire logic HOLD,
   input wire logic FB_PULSE,
   input wire logic PUMP_UP,
   input wire logic PUMP_DOWN,
   input wire logic [1:0] VCO_RANGE,
   input wire logic [23:0] GAIN_RGB,
   input wire logic [20:0] OFFSET_RGB,
   input wire logic SOG_NEGATIVE
);
   import ppd_pkg::*;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   a_fb_one_cycle: assert property (FB_PULSE |=> !FB_PULSE) else $error("fb wide");
   a_hold_no_pump: assert property ($past(HOLD) |-> !PUMP_UP && !PUMP_DOWN)
      else $error("pump in hold");
   a_pumps_apart: assert property (!(PUMP_UP && PUMP_DOWN)) else $error("both pumps");
   a_up_from_sync: assert property ($rose(PUMP_UP) |-> $past(HSYNC) && !$past(HSYNC, 2))
      else $error("up without sync");
   a_down_on_fb: assert property ($rose(PUMP_DOWN) |-> FB_PULSE) else $error("down early");
   a_sog_negative: assert property (SOG_NEGATIVE) else $error("sog polarity");
   a_gain_write: assert property (REG_REQ.we && REG_REQ.addr == 8'h08
      |=> GAIN_RGB[7:0] == $past(REG_REQ.wdata)) else $error("red gain");
   a_ofs_write: assert property (REG_REQ.we && REG_REQ.addr == 8'h0D
      |=> OFFSET_RGB[20:14] == $past(REG_REQ.wdata[7:1])) else $error("blue ofs");
   a_range_write: assert property (REG_REQ.we && REG_REQ.addr == 8'h03
      |=> VCO_RANGE == $past(REG_REQ.wdata[7:6])) else $error("range");
   c_up: cover property (PUMP_UP);
   c_down: cover property (PUMP_DOWN);
   c_hold: cover property (HOLD && HSYNC);
endmodule : ppd_checker
bind ppd_core ppd_checker i_chk (.REF_CLK, .RESETN, .REG_REQ, .HSYNC, .HOLD, .FB_PULSE,
   .PUMP_UP, .PUMP_DOWN, .VCO_RANGE, .GAIN_RGB, .OFFSET_RGB, .SOG_NEGATIVE);

// [verification/ppd_sync_src.sv]
/* Graphics source model: periodic active high sync.
   Assumes the bench clock. */
`timescale 1ns/1ps
module ppd_sync_src #(parameter int PER = 230) (
   input wire logic clk,
   input wire logic en,
   output logic hsync
);
   int n = 0;
   initial hsync = 0;
   always @(posedge clk) begin
      n <= (n + 1) % PER;
      hsync <= #1 en && (n < 8);
   end
endmodule : ppd_sync_src

// [verification/tb.sv]
/* Self-checking bench for ppd_core.
   Assumes ppd_sync_src and ppd_checker. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %s exp %h got %h", n, e, a); end end
module tb;
   import ppd_pkg::*;
   logic clk = 0, rstn = 0, hold = 0, sen = 0, go = 0, p1 = 0, seen = 0, hs, fb;
   ppd_reg_req_s req = '0;
   logic [7:0] rd, e;
   logic [1:0] rng;
   logic [2:0] pc;
   logic [4:0] sth;
   logic [7:0] q[$];
   int mismatches = 0, check_count = 0, per = 1694, cnt = 0;
   initial forever #2 clk = ~clk;
   ppd_sync_src #(.PER(230)) i_src (.clk(clk), .en(sen), .hsync(hs));
   ppd_core i_dut (.REF_CLK(clk), .RESETN(rstn), .REG_REQ(req), .HSYNC(hs), .HOLD(hold),
      .REG_RDATA(rd), .FB_PULSE(fb), .PUMP_UP(), .PUMP_DOWN(), .VCO_RANGE(rng),
      .PUMP_CODE(pc), .GAIN_RGB(), .OFFSET_RGB(), .SOG_THRESHOLD(sth), .SOG_NEGATIVE());
   always @(posedge clk) begin
      p1 <= go;
      cnt <= fb ? 1 : cnt + 1;
      if (fb) seen <= 1;
      if (p1) begin
         e = q.pop_front();
         `CHK("rdata", e, rd)
      end
      if (fb && seen && per != 0) `CHK("period", per, cnt)
   end
   task automatic stop_test();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic acc(input logic w, input logic [7:0] a, d, x);
      @(posedge clk);
      #1;
      req = '{we: w, addr: a, wdata: d};
      go = !w;
      if (!w) q.push_back(x);
   endtask : acc
   task automatic wait_fb(input int k);
      @(posedge clk);
      #1 go = 0;
      req.we = 0;
      for (int i = 0; i < 9000 && k > 0; i++) begin
         @(posedge clk);
         if (fb) k--;
      end
      if (k > 0) begin
         mismatches++;
         stop_test();
      end
   endtask : wait_fb
   initial begin
      logic [7:0] ad[10] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h20};
      logic [7:0] rv[10] = '{8'h69, 8'hD0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h78, 8'h00};
      logic [7:0] r;
      void'($urandom(61));
      repeat (10) @(posedge clk);
      #1 rstn = 1;
      sen = 1;
      foreach (ad[i]) acc(0, ad[i], 0, rv[i]);
      wait_fb(2);
      `CHK("sog_thr", 5'h0F, sth)
      r = $urandom;
      acc(1, 8'h10, r, 0);
      acc(0, 8'h10, 0, r);
      `CHK("sog_thr", r[7:3], sth)
      for (int i = 2; i < 8; i++) begin
         r = $urandom;
         acc(1, ad[i], r, 0);
         acc(0, ad[i], 0, i < 5 ? r : {r[7:1], 1'b0});
      end
      for (int i = 0; i < 4; i++) begin
         acc(1, 8'h03, {i[1:0], 6'h10}, 0);
         acc(0, 8'h03, 0, {i[1:0], 6'h10});
         `CHK("range", i[1:0], rng)
         `CHK("pump", 3'b010, pc)
      end
      per = 0;
      acc(1, 8'h01, 8'h0D, 0);
      acc(1, 8'h02, 8'hD0, 0);
      wait_fb(2);
      per = 222;
      wait_fb(3);
      #1 hold = 1;
      wait_fb(2);
      #1 hold = 0;
      per = 0;
      acc(1, 8'h01, 8'hFF, 0);
      acc(1, 8'h02, 8'hF0, 0);
      wait_fb(2);
      per = 4096;
      wait_fb(2);
      stop_test();
   end
endmodule : tb
